// [logic/sas_adc_sequencer.v]
/*
 * Control and sequencing logic of a 10-bit successive-approximation
 * converter: single and scan modes, start delay, sampling, bit decisions,
 * per-channel result storage, end flag and end interrupt.
 * Assumes an analog front end that follows chanSel, sampleHold and
 * dacCode and answers on compHigh, and a register master on ref_clk.
 */
`include "sas_defines.vh"

module sas_adc_sequencer (
    input  wire        ref_clk,
    input  wire        nrst,
    input  wire [3:0]  regAddr,
    input  wire [15:0] regWdata,
    input  wire        regWrite,
    input  wire        regRead,
    output reg  [15:0] regRdata,
    input  wire        timerTrigger,
    input  wire        externalTriggerPin,
    input  wire        compHigh,
    output reg  [9:0]  dacCode,
    output reg  [2:0]  chanSel,
    output reg         sampleHold,
    output reg         convEndIrq
);

    // ****************************************************************
    // Registers and internal state
    // ****************************************************************
    reg        convEndFlag;
    reg        endIntEnable;
    reg        convStart;
    reg        scanMode;
    reg        convClockSel;
    reg        groupSelect;
    reg        channelSelectHigh;
    reg        channelSelectLow;
    reg        trigSourceHigh;
    reg        trigSourceLow;
    reg        flagSeen;
    reg [9:0]  resultReg [0:7];
    reg [2:0]  state;
    reg [8:0]  cnt;
    reg [3:0]  bitIdx;
    reg [1:0]  chanIdx;
    reg [2:0]  presc;
    reg        trigMeta;
    reg        trigSync;
    reg        trigOld;
    reg        compMeta;
    reg        compSync;
    reg        next_start;
    reg        next_flag;
    reg        next_ie;
    integer    i;

    wire       csrWrite;
    wire       extFall;
    wire       trigFire;
    wire       phaseEnd;
    wire       convDone;
    wire       lastChan;
    wire [1:0] trigSrc;
    wire [8:0] dlyLen;

    // Picks the timing figure for the active clock select.
    function [8:0] pickLen;
        input       clkSel;
        input [8:0] lenSlow;
        input [8:0] lenFast;
        begin
            pickLen = clkSel ? lenFast : lenSlow;
        end
    endfunction

    assign csrWrite = regWrite && (regAddr == `SAS_ADDR_CSR);
    assign trigSrc  = {trigSourceHigh, trigSourceLow};
    assign extFall  = trigOld && !trigSync;
    assign trigFire = (trigSrc == `SAS_TRG_EXT && extFall) ||
                      (trigSrc == `SAS_TRG_TIMER && timerTrigger);
    assign phaseEnd = (cnt == 9'h001);
    assign convDone = convStart && (state == `SAS_ST_TAIL) && phaseEnd;
    assign lastChan = (chanIdx == {channelSelectHigh, channelSelectLow});

    // The delay pads to the next prescaler boundary, so its length depends
    // on when the start bit was set, by a write or a trigger.
    assign dlyLen = convClockSel ?
        (`SAS_DLY_BASE1 + {6'h00, `SAS_DLY_MASK1 - (presc & `SAS_DLY_MASK1)}) :
        (`SAS_DLY_BASE0 + {6'h00, `SAS_DLY_MASK0 - presc});

    // ****************************************************************
    // Pin synchronisers and prescaler
    // ****************************************************************
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            trigMeta <= 1'b1;
            trigSync <= 1'b1;
            trigOld  <= 1'b1;
            compMeta <= 1'b0;
            compSync <= 1'b0;
            presc    <= 3'h0;
        end else begin
            trigMeta <= externalTriggerPin;
            trigSync <= trigMeta;
            trigOld  <= trigSync;
            compMeta <= compHigh;
            compSync <= compMeta;
            presc    <= presc + 3'h1;
        end
    end

    // ****************************************************************
    // Next values of start, flag and enable
    // ****************************************************************
    always @* begin
        next_start = convStart;
        next_flag  = convEndFlag;
        next_ie    = endIntEnable;
        if (csrWrite) begin
            next_start = regWdata[`SAS_B_START];
            next_ie    = regWdata[`SAS_B_IE];
            if (!regWdata[`SAS_B_FLAG] && flagSeen) begin
                next_flag = 1'b0;
            end
        end
        if (convDone && !scanMode) begin
            next_start = 1'b0;
        end
        if (trigFire) begin
            next_start = 1'b1;
        end
        if (convDone && (!scanMode || lastChan)) begin
            next_flag = 1'b1;
        end
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            convStart         <= 1'b0;
            convEndFlag       <= 1'b0;
            endIntEnable      <= 1'b0;
            convEndIrq        <= 1'b0;
            scanMode          <= 1'b0;
            convClockSel      <= 1'b0;
            groupSelect       <= 1'b0;
            channelSelectHigh <= 1'b0;
            channelSelectLow  <= 1'b0;
            trigSourceHigh    <= 1'b0;
            trigSourceLow     <= 1'b0;
            flagSeen          <= 1'b0;
            regRdata          <= 16'h0000;
        end else begin
            convStart    <= next_start;
            convEndFlag  <= next_flag;
            endIntEnable <= next_ie;
            convEndIrq   <= next_flag && next_ie;
            if (csrWrite) begin
                scanMode          <= regWdata[`SAS_B_SCAN];
                convClockSel      <= regWdata[`SAS_B_CLKSEL];
                groupSelect       <= regWdata[`SAS_B_GRP];
                channelSelectHigh <= regWdata[`SAS_B_CHH];
                channelSelectLow  <= regWdata[`SAS_B_CHL];
                flagSeen          <= 1'b0;
            end else if (regRead && regAddr == `SAS_ADDR_CSR && convEndFlag) begin
                flagSeen <= 1'b1;
            end
            if (regWrite && regAddr == `SAS_ADDR_TCR) begin
                trigSourceHigh <= regWdata[1];
                trigSourceLow  <= regWdata[0];
            end
            if (regRead) begin
                if (regAddr == `SAS_ADDR_CSR) begin
                    regRdata <= {8'h00, convEndFlag, endIntEnable, convStart,
                                 scanMode, convClockSel, groupSelect,
                                 channelSelectHigh, channelSelectLow};
                end else if (regAddr == `SAS_ADDR_TCR) begin
                    regRdata <= {14'h0000, trigSourceHigh, trigSourceLow};
                end else if (regAddr[`SAS_RES_BIT]) begin
                    regRdata <= {6'h00, resultReg[regAddr[2:0]]};
                end else begin
                    regRdata <= 16'h0000;
                end
            end else begin
                regRdata <= 16'h0000;
            end
        end
    end

    // ****************************************************************
    // Conversion sequencer
    // ****************************************************************
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state      <= `SAS_ST_IDLE;
            cnt        <= 9'h000;
            bitIdx     <= 4'h0;
            chanIdx    <= 2'h0;
            chanSel    <= 3'h0;
            dacCode    <= 10'h000;
            sampleHold <= 1'b0;
            for (i = 0; i < 8; i = i + 1) begin
                resultReg[i] <= 10'h000;
            end
        end else begin
            if (state == `SAS_ST_IDLE) begin
                chanSel <= scanMode ? {groupSelect, 2'h0} :
                           {groupSelect, channelSelectHigh, channelSelectLow};
            end else if (scanMode) begin
                chanSel <= {groupSelect, chanIdx};
            end
            if (!convStart && state != `SAS_ST_IDLE) begin
                state      <= `SAS_ST_IDLE;
                sampleHold <= 1'b0;
            end else begin
                case (state)
                    `SAS_ST_IDLE: begin
                        if (convStart) begin
                            state   <= `SAS_ST_DELAY;
                            chanIdx <= 2'h0;
                            // The idle cycle that sees the start is the first
                            // delay state.
                            cnt     <= dlyLen - 9'h001;
                        end
                    end
                    `SAS_ST_DELAY, `SAS_ST_GAP: begin
                        if (phaseEnd) begin
                            state      <= `SAS_ST_SAMPLE;
                            sampleHold <= 1'b1;
                            cnt        <= pickLen(convClockSel, `SAS_SPL0,
                                                  `SAS_SPL1);
                        end else begin
                            cnt <= cnt - 9'h001;
                        end
                    end
                    `SAS_ST_SAMPLE: begin
                        if (phaseEnd) begin
                            state      <= `SAS_ST_CONV;
                            sampleHold <= 1'b0;
                            bitIdx     <= `SAS_MSB;
                            dacCode    <= 10'h200;
                            cnt        <= pickLen(convClockSel, `SAS_BIT0,
                                                  `SAS_BIT1);
                        end else begin
                            cnt <= cnt - 9'h001;
                        end
                    end
                    `SAS_ST_CONV: begin
                        if (phaseEnd) begin
                            dacCode[bitIdx] <= compSync;
                            if (bitIdx == 4'h0) begin
                                state <= `SAS_ST_TAIL;
                                cnt   <= pickLen(convClockSel, `SAS_TAIL0,
                                                 `SAS_TAIL1);
                            end else begin
                                dacCode[bitIdx - 4'h1] <= 1'b1;
                                bitIdx <= bitIdx - 4'h1;
                                cnt    <= pickLen(convClockSel, `SAS_BIT0,
                                                  `SAS_BIT1);
                            end
                        end else begin
                            cnt <= cnt - 9'h001;
                        end
                    end
                    `SAS_ST_TAIL: begin
                        if (phaseEnd) begin
                            resultReg[chanSel] <= dacCode;
                            if (scanMode) begin
                                state   <= `SAS_ST_GAP;
                                chanIdx <= lastChan ? 2'h0 :
                                           chanIdx + 2'h1;
                                cnt     <= pickLen(convClockSel, `SAS_GAP0,
                                                   `SAS_GAP1);
                            end else begin
                                state <= `SAS_ST_IDLE;
                            end
                        end else begin
                            cnt <= cnt - 9'h001;
                        end
                    end
                    default: begin
                        state <= `SAS_ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // sas_adc_sequencer

// [logic/sas_defines.vh]
/*
 * Constants of the converter sequencer: register offsets, bit positions,
 * trigger encodings, state codes and conversion timing in clock states.
 * Assumes one state equals one ref_clk period.
 */
`ifndef SAS_DEFINES_VH
`define SAS_DEFINES_VH

// Register map, word offsets on the plain register port.
`define SAS_ADDR_CSR    4'h0
`define SAS_ADDR_TCR    4'h1
`define SAS_RES_BIT     3

// Control and status register bit positions.
`define SAS_B_FLAG      7
`define SAS_B_IE        6
`define SAS_B_START     5
`define SAS_B_SCAN      4
`define SAS_B_CLKSEL    3
`define SAS_B_GRP       2
`define SAS_B_CHH       1
`define SAS_B_CHL       0

// Trigger source encodings.
`define SAS_TRG_TIMER   2'h1
`define SAS_TRG_EXT     2'h3

// Sequencer states.
`define SAS_ST_IDLE     3'h0
`define SAS_ST_DELAY    3'h1
`define SAS_ST_SAMPLE   3'h2
`define SAS_ST_CONV     3'h3
`define SAS_ST_TAIL     3'h4
`define SAS_ST_GAP      3'h5

// Clock period and timing in states, clock select 0 then 1.
`define SAS_STATE_NS    25
`define SAS_DLY_BASE0   9'h00A
`define SAS_DLY_BASE1   9'h006
`define SAS_DLY_MASK0   3'h7
`define SAS_DLY_MASK1   3'h3
`define SAS_SPL0        9'h03F
`define SAS_SPL1        9'h01F
`define SAS_BIT0        9'h012
`define SAS_BIT1        9'h009
`define SAS_TAIL0       9'h006
`define SAS_TAIL1       9'h004
`define SAS_GAP0        9'h007
`define SAS_GAP1        9'h003
`define SAS_MSB         4'h9

`endif

// [tb/sas_adc_sequencer_sva.sv]
/* Port checker of the converter sequencer.
   Assumes it is bound to sas_adc_sequencer and sees its ports only. */
`include "sas_defines.vh"
module sas_adc_sequencer_chk (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic [3:0]  regAddr,
    input wire logic [15:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [15:0] regRdata,
    input wire logic        timerTrigger,
    input wire logic        externalTriggerPin,
    input wire logic        compHigh,
    input wire logic [9:0]  dacCode,
    input wire logic [2:0]  chanSel,
    input wire logic        sampleHold,
    input wire logic        convEndIrq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic [8:0] splCnt;
    logic [9:0] period;
    logic       quiet;
    logic [1:0] stopPipe;
    // StopPipe marks the edge at which a start-clearing write cuts sampling short.
    // Quiet marks a sampling start that no write or trigger can have caused.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            splCnt <= 9'h000;
            period <= 10'h000;
            quiet  <= 1'b0;
            stopPipe <= 2'h0;
        end else begin
            stopPipe <= {stopPipe[0], regWrite && regAddr == `SAS_ADDR_CSR &&
                         !regWdata[`SAS_B_START]};
            splCnt <= sampleHold ? splCnt + 9'h001 : 9'h000;
            period <= $rose(sampleHold) ? 10'h001 : period + {9'h000, period != 10'h3FF};
            quiet  <= $rose(sampleHold) | (quiet & ~regWrite & ~timerTrigger & externalTriggerPin);
        end
    end
    sequence sampEnd;
        $fell(sampleHold) && !stopPipe[1];
    endsequence
    sequence trialMsb;
        ##[0:3] dacCode == 10'h200;
    endsequence
    sample_len_a: assert property (sampEnd |-> splCnt == 9'h03F || splCnt == 9'h01F)
        else $error("sampling phase length wrong");
    trial_msb_a: assert property (sampEnd |-> trialMsb)
        else $error("first trial code missing after sampling");
    dac_pace_a: assert property ($changed(dacCode) |=> $stable(dacCode) [*8])
        else $error("trial code changed too fast");
    chan_hold_a: assert property (sampleHold && !$rose(sampleHold) |-> $stable(chanSel))
        else $error("channel changed while sampling");
    scan_period_a: assert property ($rose(sampleHold) && quiet |-> period == 10'h100 || period == 10'h080)
        else $error("scan conversion period wrong");
    irq_fall_a: assert property ($fell(convEndIrq) |-> $past(regWrite) || $past(regWrite, 2))
        else $error("interrupt dropped without a write");
    irq_rise_a: assert property ($rose(convEndIrq) |-> !sampleHold)
        else $error("interrupt raised during sampling");
    rdata_idle_a: assert property (!$past(regRead) |-> regRdata == 16'h0000)
        else $error("read data outside read slot");
endmodule // sas_adc_sequencer_chk

// [tb/sas_analog_model.sv]
/* Analog front end model: holds the selected input while sampling and
   compares it with the trial code. Assumes input n sits at code n*123+45. */
module sas_analog_model (
    input  wire logic       ref_clk,
    input  wire logic [2:0] chanSel,
    input  wire logic       sampleHold,
    input  wire logic [9:0] dacCode,
    output logic            compHigh
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] held = 10'h000;
    always @(posedge ref_clk)
        if (sampleHold) held <= {7'h00, chanSel} * 10'h07B + 10'h02D;
    assign compHigh = held >= dacCode;
endmodule // sas_analog_model

// [tb/sas_adc_sequencer_tb.sv]
/* Self-checking bench of the converter sequencer with the analog model.
   Assumes the register map and bit positions of sas_defines.vh. */
`include "sas_defines.vh"
module sas_adc_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk, nrst, regWrite, regRead, timerTrigger, externalTriggerPin;
    logic [3:0]  regAddr;
    logic [15:0] regWdata;
    wire  [15:0] regRdata;
    wire  [9:0]  dacCode;
    wire  [2:0]  chanSel;
    wire         sampleHold, convEndIrq, compHigh;
    int          err_count, check_count, cyc, n, t;
    int          ts[4];
    logic [2:0]  c;
    logic [2:0]  chs[4];
    localparam logic [3:0] CSR = `SAS_ADDR_CSR;
    localparam logic [15:0] FL = 16'h0001 << `SAS_B_FLAG, IE = 16'h0001 << `SAS_B_IE;
    localparam logic [15:0] ST = 16'h0001 << `SAS_B_START, SC = 16'h0001 << `SAS_B_SCAN;
    localparam logic [15:0] CK = 16'h0001 << `SAS_B_CLKSEL, GR = 16'h0001 << `SAS_B_GRP;
    localparam logic [15:0] CH = 16'h0001 << `SAS_B_CHH, CL = 16'h0001 << `SAS_B_CHL;
    sas_adc_sequencer i_dut (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .timerTrigger(timerTrigger), .externalTriggerPin(externalTriggerPin),
        .compHigh(compHigh), .dacCode(dacCode), .chanSel(chanSel),
        .sampleHold(sampleHold), .convEndIrq(convEndIrq));
    sas_analog_model i_afe (.ref_clk(ref_clk), .chanSel(chanSel), .sampleHold(sampleHold),
        .dacCode(dacCode), .compHigh(compHigh));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;
    function automatic logic [15:0] lvl(input int ch);
        return 16'(ch * 16'h007B + 16'h002D);
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] exp);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        @(negedge ref_clk);
        chk(what, regRdata, exp);
        @(posedge ref_clk);
    endtask
    // Waits for the next start of sampling; ts is -1 when none comes.
    task automatic nextSample(output logic [2:0] ch, output int ts);
        logic was;
        was = 1'b1;
        ts = -1;
        ch = 3'h0;
        for (int i = 0; i < 400 && ts < 0; i++) begin
            @(negedge ref_clk);
            if (sampleHold === 1'b1 && !was) begin
                ts = cyc;
                ch = chanSel;
            end
            was = sampleHold === 1'b1;
        end
        @(posedge ref_clk);
    endtask
    // Counts edges from the write edge, which lies one cycle before the call.
    task automatic waitIrq(output int cnt);
        cnt = 1;
        do begin
            @(posedge ref_clk);
            cnt++;
            @(negedge ref_clk);
        end while (convEndIrq !== 1'b1 && cnt < 2000);
        @(posedge ref_clk);
    endtask
    task automatic pinFall();
        externalTriggerPin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        externalTriggerPin <= 1'b1;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        finish_test();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        {nrst, regWrite, regRead, timerTrigger, regAddr, regWdata} = '0;
        externalTriggerPin = 1'b1;
        {err_count, check_count, cyc} = '0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rchk("csr reset", CSR, 16'h0000);
        rchk("tcr reset", `SAS_ADDR_TCR, 16'h0000);
        rchk("unmapped", 4'h2, 16'h0000);
        $display("test reset done");
        wr(CSR, ST | IE | GR | CL);
        waitIrq(n);
        chk("single time", 16'(n >= 259 && n <= 266), 16'h0001);
        rchk("result 5", 4'hD, lvl(5));
        rchk("result 0", 4'h8, 16'h0000);
        rchk("csr end", CSR, FL | IE | GR | CL);
        wr(CSR, FL | IE | GR | CL);
        wr(CSR, IE | GR | CL);
        rchk("flag kept", CSR, FL | IE | GR | CL);
        wr(CSR, IE | GR | CL);
        repeat (2) @(posedge ref_clk);
        chk("irq clear", {15'h0000, convEndIrq}, 16'h0000);
        rchk("flag clear", CSR, IE | GR | CL);
        $display("test single done");
        wr(CSR, ST | SC | CH | IE);
        for (int i = 0; i < 4; i++) nextSample(chs[i], ts[i]);
        for (int i = 0; i < 4; i++) chk("scan chan", 16'(chs[i]), 16'(i % 3));
        chk("scan period", 16'(ts[2] - ts[1]), 16'h0100);
        chk("scan irq", {15'h0000, convEndIrq}, 16'h0001);
        rchk("scan flag", CSR, FL | ST | SC | CH | IE);
        for (int i = 0; i < 3; i++) rchk("scan result", 4'(8 + i), lvl(i));
        rchk("unselected", 4'hB, 16'h0000);
        wr(CSR, SC | CH);
        nextSample(c, t);
        chk("scan stopped", 16'(t), 16'hFFFF);
        wr(CSR, ST | SC | CH);
        nextSample(c, t);
        nextSample(c, t);
        repeat (110) @(posedge ref_clk);
        wr(CSR, SC | CH);
        wr(CSR, ST | SC | CH);
        nextSample(c, t);
        chk("restart chan", 16'(c), 16'h0000);
        wr(CSR, SC | CH);
        $display("test scan done");
        wr(`SAS_ADDR_TCR, 16'h0001);
        wr(CSR, SC | CK | GR | CL);
        timerTrigger <= 1'b1;
        @(posedge ref_clk);
        timerTrigger <= 1'b0;
        for (int i = 0; i < 3; i++) nextSample(chs[i], ts[i]);
        for (int i = 0; i < 3; i++) chk("group chan", 16'(chs[i]), 16'(4 + i % 2));
        chk("fast period", 16'(ts[1] - ts[0]), 16'h0080);
        wr(CSR, SC | CK | GR | CL);
        rchk("timer flag", CSR, FL | SC | CK | GR | CL);
        rchk("result 4", 4'hC, lvl(4));
        $display("test timer done");
        wr(CSR, IE | CK | GR | CH | CL);
        pinFall();
        nextSample(c, t);
        chk("pin ignored", 16'(t), 16'hFFFF);
        wr(`SAS_ADDR_TCR, 16'h0003);
        pinFall();
        rchk("start by pin", CSR, ST | IE | CK | GR | CH | CL);
        waitIrq(n);
        chk("pin irq", {15'h0000, convEndIrq}, 16'h0001);
        rchk("pin result", 4'hF, lvl(7));
        rchk("pin end", CSR, FL | IE | CK | GR | CH | CL);
        $display("test trigger done");
        finish_test();
    end
endmodule // sas_adc_sequencer_tb

bind sas_adc_sequencer sas_adc_sequencer_chk i_chk (.ref_clk(ref_clk), .nrst(nrst),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .timerTrigger(timerTrigger), .externalTriggerPin(externalTriggerPin),
    .compHigh(compHigh), .dacCode(dacCode), .chanSel(chanSel), .sampleHold(sampleHold),
    .convEndIrq(convEndIrq));
